/* logic/dma_pkg.sv */
// Shared constants for the two-channel cycle-steal transfer engine
package dma_pkg;
  // Register offsets (word index on the plain register port)
  localparam logic [4:0] OFS_SRC0 = 5'h00;
  localparam logic [4:0] OFS_DST0 = 5'h01;
  localparam logic [4:0] OFS_RLD0 = 5'h02;
  localparam logic [4:0] OFS_CTL0 = 5'h03;
  localparam logic [4:0] OFS_SEL0 = 5'h04;
  localparam logic [4:0] OFS_PTR0 = 5'h05;
  localparam logic [4:0] OFS_CNT0 = 5'h06;
  localparam logic [4:0] OFS_CH_STRIDE = 5'h08;
  localparam logic [4:0] OFS_BUSCFG = 5'h10;
  localparam logic [4:0] OFS_SWREQ = 5'h11;
  // Control register fields
  localparam int CTL_EN = 0;
  localparam int CTL_REQ = 1;
  localparam int CTL_UNIT = 2;
  localparam int CTL_REPEAT = 3;
  localparam int CTL_SRC_FWD = 4;
  localparam int CTL_DST_FWD = 5;
  // Bus configuration fields
  localparam int CFG_BUS8 = 0;
  localparam int CFG_EXPANDED = 1;
  localparam int CFG_MUX = 2;
  // Request source select codes
  localparam logic [1:0] SEL_PERIPH = 2'h0;
  localparam logic [1:0] SEL_SOFT = 2'h1;
  localparam logic [1:0] SEL_EXT_FALL = 2'h2;
  localparam logic [1:0] SEL_EXT_BOTH = 2'h3;
  // Access coefficients in bus-clock cycles
  localparam logic [1:0] COEF_PLAIN = 2'h1;
  localparam logic [1:0] COEF_WAIT = 2'h2;
  localparam logic [1:0] COEF_MUX = 2'h3;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
endpackage

/* logic/dma_access_timer.sv */
// Bus access sequencer: counts the cycles of one read or write access
`timescale 1ns/1ps
`default_nettype none
module dma_access_timer
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  // Access control
  input wire logic start,
  input wire logic [1:0] coef,
  output logic done
);
  logic [1:0] used_q;
  logic busy_q;

  // Cycles spent in the access; coef is read live, because the address
  // that decides it is only on the bus once the access has begun
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      used_q <= 2'h0;
      busy_q <= 1'b0;
    end
    else if (clk_en)
    begin
      if (start)
      begin
        used_q <= 2'h0;
        busy_q <= 1'b1;
      end
      else if (busy_q && !done)
        used_q <= used_q + 2'h1;
      else
        busy_q <= 1'b0;
    end
  end

  // Done on the cycle that completes coef cycles
  assign done = busy_q && (used_q + 2'h1 >= coef);
endmodule
`default_nettype wire

/* logic/dma_cycle_steal.sv */
// Two-channel cycle-stealing transfer engine with register port
`timescale 1ns/1ps
`default_nettype none
// Operation
// [R01] Waited memory or function area access adds one bus cycle; on a multiplexed bus every access takes three, waited or not.
// [R02] Unit cycles are reads times j plus writes times k.
// [R03] Byte: one access each; odd word or 8-bit bus: two each.
// [R04] Writing one to enable activates; requests then start transfers.
// [R05] First transfer loads forward pointer and counter from reload.
// [R06] Rewriting enable while active restarts from initial state.
// [R07] Request source is peripheral, software, or external pin.
// [R08] Request bit sets on selected request regardless of enable.
// [R09] Request bit clears just before the transfer begins.
// [R10] Software may clear request bit, never set it.
// [R11] Software clears request bit after changing source selection.
// [R12] Peripheral request sets bit with peripheral interrupt flag.
// [R13] External pin request follows selected edge.
// [R14] Simultaneous requests set both bits in one cycle.
// [R15] Channel zero first, processor access, then channel one.
// [R16] Single mode underflow clears enable.
// [R17] Repeat mode underflow reloads counter, stays active.
// [R18] Each channel pulses interrupt on counter underflow.
// [R19] Each channel uses only its own external pin.
// [R20] Pointer advances by unit size, counter decrements.
// [R21] Read then write atomically, then bus returns.
module dma_cycle_steal
#(
  parameter int ADDR_W = 20
)
(
  // Clock, enable and reset
  input wire logic clk,
  input wire logic clk_en,
  input wire logic reset,
  // Register port
  input wire logic [4:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Request sources
  input wire logic [1:0] periph_irq,
  input wire logic [1:0] external_interrupt_input,
  // Shared bus
  input wire logic cpu_access_done,
  input wire logic src_waited,
  input wire logic dst_waited,
  output logic bus_grant,
  output logic bus_write,
  output logic [ADDR_W-1:0] bus_addr,
  output logic bus_word,
  output logic [15:0] bus_wdata,
  input wire logic [15:0] bus_rdata,
  // Underflow interrupts
  output logic [1:0] dma_irq
);
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b000,
    ST_READ = 3'b001,
    ST_WRITE = 3'b010,
    ST_YIELD = 3'b011
  } state_e;

  state_e state_q;
  logic [ADDR_W-1:0] src_q [2];
  logic [ADDR_W-1:0] dst_q [2];
  logic [ADDR_W-1:0] ptr_q [2];
  logic [15:0] rld_q [2];
  logic [15:0] cnt_q [2];
  logic [5:0] ctl_q [2];
  logic [1:0] sel_q [2];
  logic [1:0] req_q;
  logic [1:0] fresh_q;
  logic [1:0] ext_q;
  logic [2:0] buscfg_q;
  logic ch_q;
  logic part_q;
  logic [15:0] data_q;
  logic [1:0] hit;
  logic [1:0] req_set;
  logic [1:0] req_clr;
  logic [1:0] start_ch;
  logic acc_start;
  logic acc_done;
  logic [1:0] acc_coef;
  logic two_acc;
  logic [ADDR_W-1:0] cur_src;
  logic [ADDR_W-1:0] cur_dst;
  logic [15:0] cur_cnt;
  logic underflow;
  logic [5:0] cc;

  // Index of a register within a channel block
  function automatic logic [4:0] chofs(input logic [4:0] base, input int c);
    chofs = base + (c != 0 ? dma_pkg::OFS_CH_STRIDE : 5'h00);
  endfunction

  // Access coefficient for one side of a transfer
  function automatic logic [1:0] coef_of(input logic waited,
    input logic mux);
    // [R01] waited costs one more, except on a multiplexed bus
    if (mux)
      coef_of = dma_pkg::COEF_MUX;
    else if (waited)
      coef_of = dma_pkg::COEF_WAIT;
    else
      coef_of = dma_pkg::COEF_PLAIN;
  endfunction

  // Request source decode and pin edge detection per channel
  always_comb
  begin
    for (int c = 0; c < 2; c++)
    begin
      // [R07] source select
      case (sel_q[c])
        dma_pkg::SEL_PERIPH: hit[c] = periph_irq[c];
        dma_pkg::SEL_SOFT: hit[c] = reg_wr &&
          reg_addr == dma_pkg::OFS_SWREQ && reg_wdata[c];
        // [R13] falling edge, own pin only
        dma_pkg::SEL_EXT_FALL: hit[c] = ext_q[c] &&
          !external_interrupt_input[c];
        dma_pkg::SEL_EXT_BOTH: hit[c] = ext_q[c] !=
          external_interrupt_input[c];
        default: hit[c] = 1'b0;
      endcase
    end
  end

  // External pin history; pins are synchronous to clk
  always_ff @(posedge clk)
  begin
    if (reset)
      ext_q <= 2'h3;
    else if (clk_en)
      ext_q <= external_interrupt_input; // [R19] pin c feeds channel c
  end

  // Arbitration: channel zero wins, one waits for a processor access
  always_comb
  begin
    start_ch = 2'h0;
    if (state_q == ST_IDLE)
    begin
      // [R15] channel zero priority
      if (req_q[0] && ctl_q[0][dma_pkg::CTL_EN])
        start_ch = 2'h1;
      else if (req_q[1] && ctl_q[1][dma_pkg::CTL_EN])
        start_ch = 2'h2;
    end
  end

  // Request flags: hardware set wins over any clear
  always_comb
  begin
    for (int c = 0; c < 2; c++)
    begin
      // [R14] both channels sampled in one cycle
      req_set[c] = hit[c];
      // [R10] software clear only
      req_clr[c] = start_ch[c] || (reg_wr &&
        reg_addr == chofs(dma_pkg::OFS_CTL0, c) &&
        !reg_wdata[dma_pkg::CTL_REQ]);
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      req_q <= 2'h0;
    else if (clk_en)
      // [R08] set regardless of enable; [R12] same cycle as irq
      // [R09] cleared as the transfer starts
      req_q <= req_set | (req_q & ~req_clr);
  end

  // Current channel views
  assign cur_src = src_q[ch_q];
  assign cur_dst = dst_q[ch_q];
  assign cur_cnt = cnt_q[ch_q];
  assign cc = ctl_q[ch_q];
  // [R03] two accesses for odd word or 8-bit expanded bus
  assign two_acc = !cc[dma_pkg::CTL_UNIT] &&
    ((buscfg_q[dma_pkg::CFG_BUS8] && buscfg_q[dma_pkg::CFG_EXPANDED]) ||
    bus_addr[0]);
  // [R02] read side j, write side k
  assign acc_coef = coef_of(state_q == ST_READ ? src_waited : dst_waited,
    buscfg_q[dma_pkg::CFG_MUX]);
  assign acc_start = (start_ch != 2'h0) ||
    ((state_q == ST_READ || state_q == ST_WRITE) && acc_done &&
    !(state_q == ST_WRITE && (part_q || !two_acc)));
  assign underflow = state_q == ST_WRITE && acc_done &&
    (part_q || !two_acc) && cur_cnt == 16'h0000;

  dma_access_timer dma_access_timer_inst
  (
    .clk(clk),
    .reset(reset),
    .clk_en(clk_en),
    .start(acc_start),
    .coef(acc_coef),
    .done(acc_done)
  );

  // Transfer sequencer: read, write, then hand the bus back
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_q <= ST_IDLE;
      ch_q <= 1'b0;
      part_q <= 1'b0;
      data_q <= 16'h0000;
    end
    else if (clk_en)
    begin
      case (state_q)
        ST_IDLE:
          if (start_ch != 2'h0)
          begin
            ch_q <= start_ch[1];
            part_q <= 1'b0;
            state_q <= ST_READ;
          end
        // [R21] read then write under one grant
        ST_READ:
          if (acc_done)
          begin
            if (part_q)
              data_q[15:8] <= bus_rdata[7:0];
            else
              data_q <= bus_rdata;
            if (two_acc && !part_q)
              part_q <= 1'b1;
            else
            begin
              part_q <= 1'b0;
              state_q <= ST_WRITE;
            end
          end
        ST_WRITE:
          if (acc_done)
          begin
            if (two_acc && !part_q)
              part_q <= 1'b1;
            else
              state_q <= ST_YIELD;
          end
        // Processor must finish one access before the next steal
        ST_YIELD:
          if (cpu_access_done)
            state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Channel registers, pointer and counter
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      buscfg_q <= 3'h0;
      for (int c = 0; c < 2; c++)
      begin
        src_q[c] <= '0;
        dst_q[c] <= '0;
        ptr_q[c] <= '0;
        rld_q[c] <= 16'h0000;
        cnt_q[c] <= 16'h0000;
        ctl_q[c] <= 6'h00;
        sel_q[c] <= dma_pkg::SEL_PERIPH;
        fresh_q[c] <= 1'b0;
      end
    end
    else if (clk_en)
    begin
      if (reg_wr && reg_addr == dma_pkg::OFS_BUSCFG)
        buscfg_q <= reg_wdata[2:0];
      for (int c = 0; c < 2; c++)
      begin
        if (reg_wr)
        begin
          if (reg_addr == chofs(dma_pkg::OFS_SRC0, c))
            src_q[c] <= reg_wdata[ADDR_W-1:0];
          if (reg_addr == chofs(dma_pkg::OFS_DST0, c))
            dst_q[c] <= reg_wdata[ADDR_W-1:0];
          if (reg_addr == chofs(dma_pkg::OFS_RLD0, c))
            rld_q[c] <= reg_wdata[15:0];
          if (reg_addr == chofs(dma_pkg::OFS_SEL0, c))
            sel_q[c] <= reg_wdata[1:0];
          if (reg_addr == chofs(dma_pkg::OFS_CTL0, c))
          begin
            ctl_q[c] <= {reg_wdata[5:2], 1'b0, reg_wdata[0]};
            // [R04] [R06] any write of one rearms initial state
            if (reg_wdata[dma_pkg::CTL_EN])
              fresh_q[c] <= 1'b1;
          end
        end
        if (start_ch[c] && fresh_q[c])
        begin
          // [R05] load pointer and counter on first start
          ptr_q[c] <= ctl_q[c][dma_pkg::CTL_SRC_FWD] ? src_q[c] : dst_q[c];
          cnt_q[c] <= rld_q[c];
          fresh_q[c] <= 1'b0;
        end
      end
      if (state_q == ST_WRITE && acc_done && (part_q || !two_acc))
      begin
        // [R20] advance pointer, count down
        ptr_q[ch_q] <= ptr_q[ch_q] +
          (cc[dma_pkg::CTL_UNIT] ? ADDR_W'(1) : ADDR_W'(2));
        cnt_q[ch_q] <= cur_cnt - 16'h0001;
        if (underflow)
        begin
          // [R17] repeat reloads
          if (cc[dma_pkg::CTL_REPEAT])
            cnt_q[ch_q] <= rld_q[ch_q];
          // [R16] single mode disables
          else
            ctl_q[ch_q][dma_pkg::CTL_EN] <= 1'b0;
        end
      end
    end
  end

  // Underflow interrupt pulses
  always_ff @(posedge clk)
  begin
    if (reset)
      dma_irq <= 2'h0;
    else if (clk_en)
      // [R18] one pulse per underflow
      dma_irq <= {underflow && ch_q, underflow && !ch_q};
  end

  // Bus address and write data; forward side uses the pointer
  always_comb
  begin
    if (state_q == ST_READ)
      bus_addr = cc[dma_pkg::CTL_SRC_FWD] ? ptr_q[ch_q] : cur_src;
    else
      bus_addr = cc[dma_pkg::CTL_DST_FWD] ? ptr_q[ch_q] : cur_dst;
    if (part_q)
      bus_addr = bus_addr + ADDR_W'(1);
  end
  assign bus_grant = state_q == ST_READ || state_q == ST_WRITE;
  assign bus_write = state_q == ST_WRITE;
  assign bus_word = !cc[dma_pkg::CTL_UNIT] && !two_acc && !part_q;
  assign bus_wdata = part_q ? {8'h00, data_q[15:8]} : data_q;

  // Register read data, one cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (reset)
      reg_rdata <= dma_pkg::RST_ZERO;
    else if (clk_en)
    begin
      reg_rdata <= dma_pkg::RST_ZERO;
      if (reg_rd)
      begin
        if (reg_addr == dma_pkg::OFS_BUSCFG)
          reg_rdata <= {29'h0, buscfg_q};
        for (int c = 0; c < 2; c++)
        begin
          if (reg_addr == chofs(dma_pkg::OFS_SRC0, c))
            reg_rdata <= 32'(src_q[c]);
          if (reg_addr == chofs(dma_pkg::OFS_DST0, c))
            reg_rdata <= 32'(dst_q[c]);
          if (reg_addr == chofs(dma_pkg::OFS_RLD0, c))
            reg_rdata <= {16'h0000, rld_q[c]};
          if (reg_addr == chofs(dma_pkg::OFS_CTL0, c))
            reg_rdata <= {26'h0, ctl_q[c][5:2], req_q[c], ctl_q[c][0]};
          if (reg_addr == chofs(dma_pkg::OFS_SEL0, c))
            reg_rdata <= {30'h0, sel_q[c]};
          if (reg_addr == chofs(dma_pkg::OFS_PTR0, c))
            reg_rdata <= 32'(ptr_q[c]);
          if (reg_addr == chofs(dma_pkg::OFS_CNT0, c))
            reg_rdata <= {16'h0000, cnt_q[c]};
        end
      end
    end
  end
endmodule
`default_nettype wire

/* bench/dma_bus_model.sv */
// Memory and processor model on the far side of the shared bus
`timescale 1ns/1ps
`default_nettype none
module dma_bus_model
#(
  parameter int ADDR_W = 20
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Shared bus from the engine
  input wire logic bus_grant,
  input wire logic bus_write,
  input wire logic [ADDR_W-1:0] bus_addr,
  output logic src_waited,
  output logic dst_waited,
  output logic [15:0] bus_rdata,
  // Processor side
  output logic cpu_access_done
);
  logic [15:0] mem_word;
  logic g_q;
  logic [2:0] turn_q;
  // Address bit 8 marks the waited region for both directions
  assign src_waited = bus_addr[8];
  assign dst_waited = bus_addr[8];
  // Outside reads the data flip, so stale values never pass as good
  assign mem_word = bus_addr[15:0] ^ 16'h5A3C;
  assign bus_rdata = (bus_grant && !bus_write) ? mem_word : ~mem_word;
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      g_q <= 1'b0;
      turn_q <= 3'h0;
    end
    else
    begin
      g_q <= bus_grant;
      turn_q <= {turn_q[1:0], g_q && !bus_grant};
    end
  end
  assign cpu_access_done = turn_q[1]; // One access two cycles after release
endmodule
`default_nettype wire

/* bench/dma_cycle_steal_asserts.sv */
// Concurrent checks on the cycle-steal engine ports
`timescale 1ns/1ps
`default_nettype none
module dma_cycle_steal_asserts
#(
  parameter int ADDR_W = 20
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire logic [4:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Shared bus
  input wire logic cpu_access_done,
  input wire logic src_waited,
  input wire logic bus_grant,
  input wire logic bus_write,
  input wire logic [ADDR_W-1:0] bus_addr,
  // Underflow interrupts
  input wire logic [1:0] dma_irq
);
  logic cfg_q;
  logic wait_q;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // 8-bit expanded or multiplexed bus settings change access length
  always_ff @(posedge clk)
  begin
    if (reset)
      cfg_q <= 1'b0;
    else if (reg_wr && reg_addr == dma_pkg::OFS_BUSCFG)
      cfg_q <= |reg_wdata[2:0];
  end
  // Set after the bus returns, cleared once the processor used it
  always_ff @(posedge clk)
  begin
    if (reset || cpu_access_done)
      wait_q <= 1'b0;
    else if ($fell(bus_grant))
      wait_q <= 1'b1;
  end
  sequence s_start;
    $rose(bus_grant) && !bus_write && !bus_addr[0] && !cfg_q;
  endsequence
  a_read_first: assert property ($rose(bus_grant) |-> !bus_write)
    else $error("unit did not open with a read");
  a_write_end: assert property ($fell(bus_grant) |-> $past(bus_write))
    else $error("unit did not close with a write");
  a_grant_bound: assert property ($rose(bus_grant) |-> ##[1:12] !bus_grant)
    else $error("bus held too long");
  a_plain_read: assert property (s_start ##0 !src_waited |=> bus_write)
    else $error("plain read not one cycle");
  a_waited_read: assert property (s_start ##0 src_waited |=> !bus_write ##1 bus_write)
    else $error("waited read not two cycles");
  a_cpu_turn: assert property (wait_q |-> !bus_grant)
    else $error("bus taken before processor access");
  a_irq_end: assert property (dma_irq != 2'h0 |-> $past(bus_grant && bus_write))
    else $error("interrupt not at end of unit");
  a_irq_pulse: assert property ($rose(dma_irq[0]) |=> !dma_irq[0])
    else $error("interrupt longer than one cycle");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data outside read slot");
endmodule
bind dma_cycle_steal dma_cycle_steal_asserts #(.ADDR_W(ADDR_W))
  dma_cycle_steal_asserts_inst (.clk(clk), .reset(reset),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_access_done(cpu_access_done),
  .src_waited(src_waited), .bus_grant(bus_grant), .bus_write(bus_write),
  .bus_addr(bus_addr), .dma_irq(dma_irq));
`default_nettype wire

/* bench/dma_cycle_steal_tb.sv */
// Register-level bench for the cycle-steal engine
`timescale 1ns/1ps
`default_nettype none
module dma_cycle_steal_tb;
  localparam logic [4:0] C1 = dma_pkg::OFS_CTL0 + dma_pkg::OFS_CH_STRIDE;
  localparam logic [4:0] S1 = dma_pkg::OFS_SRC0 + dma_pkg::OFS_CH_STRIDE;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [4:0] reg_addr = 5'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [1:0] periph_irq = 2'h0;
  logic [1:0] pin = 2'h3;
  logic [31:0] reg_rdata;
  logic cpu_access_done, src_waited, dst_waited, bus_grant, bus_write;
  logic bus_word;
  logic [19:0] bus_addr;
  logic [15:0] bus_wdata, bus_rdata, wd;
  logic [1:0] dma_irq;
  logic g_q = 1'b0;
  logic bw;
  logic [19:0] seq [4];
  int n = 0, gcyc = 0, ic0 = 0, ic1 = 0, cyc = 0, errors = 0, checked = 0;
  always #4 clk = ~clk;
  dma_cycle_steal #(.ADDR_W(20)) dma_cycle_steal_inst (.clk(clk),
    .clk_en(1'b1), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .periph_irq(periph_irq),
    .external_interrupt_input(pin), .cpu_access_done(cpu_access_done),
    .src_waited(src_waited), .dst_waited(dst_waited),
    .bus_grant(bus_grant), .bus_write(bus_write), .bus_addr(bus_addr),
    .bus_word(bus_word), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .dma_irq(dma_irq));
  dma_bus_model #(.ADDR_W(20)) dma_bus_model_inst (.clk(clk),
    .reset(reset), .bus_grant(bus_grant), .bus_write(bus_write),
    .bus_addr(bus_addr), .src_waited(src_waited),
    .dst_waited(dst_waited), .bus_rdata(bus_rdata),
    .cpu_access_done(cpu_access_done));
  // Logs each stolen unit; a hang is cut short by the cycle ceiling
  always @(posedge clk)
  begin
    g_q <= bus_grant;
    cyc++;
    if (bus_grant === 1'b1)
      gcyc++;
    if (bus_grant === 1'b1 && g_q === 1'b0 && n < 4)
    begin
      seq[n] = bus_addr;
      n++;
    end
    if (bus_grant === 1'b1 && g_q === 1'b0)
      bw = bus_word;
    if (bus_grant === 1'b1 && bus_write === 1'b1)
      wd = bus_wdata;
    if (dma_irq[0] === 1'b1)
      ic0++;
    if (dma_irq[1] === 1'b1)
      ic1++;
    if (cyc == 20000)
    begin
      errors++;
      end_sim();
    end
  end
  task end_sim;
    if (errors == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task check(input string nm, input logic [31:0] seen, input logic [31:0] e);
    checked++;
    if (seen !== e)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, seen);
    end
  endtask
  task wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Read data are looked at in the one cycle they stand
  task rd(input string nm, input logic [4:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check(nm, reg_rdata, e);
  endtask
  // Waits for u units under a bound, then lets the processor turn pass
  task run(input int u);
    int k;
    repeat (u)
    begin
      k = 0;
      while (bus_grant !== 1'b1 && k < 200)
      begin
        @(posedge clk);
        k++;
      end
      while (bus_grant !== 1'b0 && k < 200)
      begin
        @(posedge clk);
        k++;
      end
      check("unit", k < 200, 1);
    end
    repeat (6) @(posedge clk);
  endtask
  // One software-started channel zero unit under a bus setting
  task word_unit(input logic [31:0] cfg, input int c, input logic w,
    input logic [15:0] d);
    wr(dma_pkg::OFS_BUSCFG, cfg);
    gcyc = 0;
    wr(dma_pkg::OFS_SWREQ, 32'h1);
    run(1);
    check("word cycles", gcyc, c);
    check("bus word", bw, w);
    check("word data", wd, d);
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    rd("ctl0", dma_pkg::OFS_CTL0, 32'h0);
    rd("ptr0", dma_pkg::OFS_PTR0, 32'h0);
    rd("unmapped", 5'h1F, 32'h0);
    wr(dma_pkg::OFS_BUSCFG, 32'h0);
    // Peripheral request on an idle channel, then software clear
    @(posedge clk);
    periph_irq <= 2'h2;
    @(posedge clk);
    periph_irq <= 2'h0;
    rd("req1", C1, 32'h2);
    wr(C1, 32'h2);
    rd("req1 set", C1, 32'h2);
    wr(C1, 32'h0);
    rd("req1 clr", C1, 32'h0);
    // Channel zero byte units, software request, single mode
    wr(dma_pkg::OFS_SRC0, 32'h100);
    wr(dma_pkg::OFS_DST0, 32'h200);
    wr(dma_pkg::OFS_RLD0, 32'h1);
    wr(dma_pkg::OFS_SEL0, 32'(dma_pkg::SEL_SOFT));
    wr(dma_pkg::OFS_CTL0, 32'h15);
    wr(dma_pkg::OFS_SWREQ, 32'h1);
    run(1);
    check("cycles", gcyc, 3);
    check("addr", seq[0], 20'h100);
    check("data", wd[7:0], 8'h3C);
    wr(dma_pkg::OFS_SWREQ, 32'h1);
    run(1);
    rd("ptr0", dma_pkg::OFS_PTR0, 32'h102);
    rd("ctl0", dma_pkg::OFS_CTL0, 32'h14);
    check("irq0", ic0, 1);
    // Both channels at once; channel one odd word in repeat mode
    wr(S1, 32'h41);
    wr(S1 + 5'h01, 32'h81);
    wr(S1 + 5'h02, 32'h0);
    wr(S1 + 5'h03, 32'h19);
    wr(S1 + 5'h04, 32'(dma_pkg::SEL_SOFT));
    wr(C1, 32'h19);
    wr(dma_pkg::OFS_CTL0, 32'h15);
    n = 0;
    gcyc = 0;
    wr(dma_pkg::OFS_SWREQ, 32'h3);
    run(2);
    check("first", seq[0], 20'h100);
    check("second", seq[1], 20'h41);
    check("cycles", gcyc, 7);
    check("irq1", ic1, 1);
    rd("ctl1", C1, 32'h19);
    rd("ptr1", S1 + 5'h05, 32'h43);
    // Rewriting enable on an active channel restarts it
    wr(C1, 32'h19);
    n = 0;
    wr(dma_pkg::OFS_SWREQ, 32'h2);
    run(1);
    check("restart", seq[0], 20'h41);
    // Pin requests on channel zero, falling edge only
    wr(dma_pkg::OFS_SEL0, 32'(dma_pkg::SEL_EXT_FALL));
    wr(dma_pkg::OFS_CTL0, 32'h15);
    n = 0;
    pin <= 2'h1;
    repeat (20) @(posedge clk);
    check("other pin", n, 0);
    pin <= 2'h0;
    run(1);
    check("pin fall", seq[0], 20'h100);
    pin <= 2'h3;
    repeat (20) @(posedge clk);
    check("pin rise", n, 1);
    // Word units on 16-bit, 8-bit expanded and multiplexed buses
    wr(dma_pkg::OFS_SRC0, 32'h10);
    wr(dma_pkg::OFS_DST0, 32'h20);
    wr(dma_pkg::OFS_RLD0, 32'h2);
    wr(dma_pkg::OFS_SEL0, 32'(dma_pkg::SEL_SOFT));
    wr(dma_pkg::OFS_CTL0, 32'h21);
    word_unit(32'h0, 2, 1'b1, 16'h5A2C);
    word_unit(32'h3, 4, 1'b0, 16'h002D);
    word_unit(32'h4, 6, 1'b1, 16'h5A2C);
    rd("ptr0 dst", dma_pkg::OFS_PTR0, 32'h26);
    rd("ctl0 word", dma_pkg::OFS_CTL0, 32'h20);
    check("irq0 word", ic0, 2);
    end_sim();
  end
endmodule
`default_nettype wire
